// ==== inc/tfg_cfg.svh ====
`ifndef TFG_CFG_SVH
`define TFG_CFG_SVH

// Register byte offsets
`define TFG_REG_CTRL       8'h00
`define TFG_REG_FORMAT     8'h04
`define TFG_REG_SYNC       8'h08
`define TFG_REG_CNT_LIM    8'h0c
`define TFG_REG_BLANK      8'h10
`define TFG_REG_BLANK_RUN  8'h14
`define TFG_REG_ERR_CMD    8'h18
`define TFG_REG_ENTRY_IDX  8'h1c
`define TFG_REG_ENTRY_VAL  8'h20
`define TFG_REG_STATUS     8'h24

// CTRL fields
`define TFG_CTRL_EN_BIT    0
`define TFG_CTRL_LSB_BIT   1
`define TFG_CTRL_DIR_BIT   2
`define TFG_CTRL_CMIN_BIT  3
`define TFG_CTRL_BMODE_LSB 4

// FORMAT fields: word length in [4:0], words per frame in [31:16]
`define TFG_FMT_WLEN_LSB   0
`define TFG_FMT_WPF_LSB    16

// Entry value fields: opcode [17:16], operand [15:0]
`define TFG_ENT_OP_LSB     16

// Reset values
`define TFG_RST_WLEN       5'h10
`define TFG_RST_WPF        16'h0010
`define TFG_RST_CMAX       16'hffff

`define TFG_PROG_DEPTH     32
`define TFG_SYNC_HALF_W    16

`endif

// ==== inc/tfg_pkg.sv ====
package tfg_pkg;
  typedef enum logic [1:0] {
    TFG_OP_SYNC,
    TFG_OP_IMM,
    TFG_OP_REPEAT,
    TFG_OP_FCOUNT
  } tfg_op_t;

  typedef enum logic [1:0] {
    TFG_BLANK_OFF,
    TFG_BLANK_FREE,
    TFG_BLANK_FRAME
  } tfg_blank_mode_t;
endpackage

// ==== logic/tfg_blanker.sv ====
`timescale 1ns/1ps
`include "tfg_cfg.svh"
module tfg_blanker
  import tfg_pkg::*;
#(
  parameter int CW = 16
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_bit_valid,
  input wire logic i_bit,
  input wire logic i_frame_start,
  input wire tfg_blank_mode_t i_mode,
  input wire logic [CW-1:0] i_blank_len,
  input wire logic [CW-1:0] i_run_len,
  output logic o_bit,
  output logic o_blanking
);
  logic blank_q;
  logic [CW-1:0] cnt_q;
  logic done_q;

  // ****************
  // Blanking timer
  // ****************
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      blank_q <= 1'b0;
      cnt_q <= '0;
      done_q <= 1'b0;
    end else if (i_mode == TFG_BLANK_OFF) begin
      blank_q <= 1'b0;
      cnt_q <= '0;
      done_q <= 1'b0;
    end else if (i_bit_valid) begin
      if (i_mode == TFG_BLANK_FRAME && i_frame_start) begin
        // Offset counted from the frame's first bit; once per frame
        done_q <= 1'b0;
        blank_q <= 1'b0;
        cnt_q <= CW'(1);
      end else if (blank_q) begin
        if (cnt_q + CW'(1) >= i_blank_len) begin
          blank_q <= 1'b0;
          cnt_q <= '0;
          done_q <= (i_mode == TFG_BLANK_FRAME);
        end else begin
          cnt_q <= cnt_q + CW'(1);
        end
      end else if (!done_q) begin
        if (cnt_q + CW'(1) >= i_run_len && i_blank_len != '0) begin
          blank_q <= 1'b1;
          cnt_q <= '0;
        end else begin
          cnt_q <= cnt_q + CW'(1);
        end
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_bit <= 1'b0;
      o_blanking <= 1'b0;
    end else if (i_bit_valid) begin
      o_bit <= blank_q ? 1'b0 : i_bit;
      o_blanking <= blank_q;
    end
  end

  property p_blank_zero;
    @(posedge i_clock) disable iff (!i_rst_n)
      (i_bit_valid && blank_q) |=> !o_bit;
  endproperty
  a_blank_zero: assert property (p_blank_zero)
    else $error("Blanked bit not zero");

  property p_off_passes;
    @(posedge i_clock) disable iff (!i_rst_n)
      (i_bit_valid && i_mode == TFG_BLANK_OFF) |=> !blank_q;
  endproperty
  a_off_passes: assert property (p_off_passes)
    else $error("Blanking active while off");

  property p_frame_restart;
    @(posedge i_clock) disable iff (!i_rst_n)
      (i_bit_valid && i_mode == TFG_BLANK_FRAME && i_frame_start)
        |=> (!done_q && !blank_q);
  endproperty
  a_frame_restart: assert property (p_frame_restart)
    else $error("Frame start did not rearm blanking");
endmodule

// ==== logic/tfg_frame_gen.sv ====
// The register offsets and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "tfg_cfg.svh"
module tfg_frame_gen
  import tfg_pkg::*;
#(
  parameter int DEPTH = `TFG_PROG_DEPTH,
  parameter int WMAX = 16
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic o_tx_bit,
  output logic o_tx_bit_valid,
  output logic o_frame_start,
  output logic o_blanking
);
  localparam int IW = $clog2(DEPTH);

  // ****************
  // Configuration
  // ****************
  logic en_q, lsb_q, dir_q, cmin_q;
  tfg_blank_mode_t bmode_q;
  logic [4:0] wlen_q;
  logic [15:0] wpf_q;
  logic [31:0] sync_q;
  logic [15:0] cmax_q;
  logic [15:0] blen_q, boff_q;
  logic [5:0] idx_q;
  logic [17:0] prog_q [DEPTH];
  logic err_req_q;
  logic [15:0] fcnt_q;

  // AXI write path
  logic aw_have_q, w_have_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic wr_go;
  logic [IW-1:0] sel;

  assign wr_go = aw_have_q && w_have_q && !o_bvalid;
  assign sel = IW'(idx_q - 6'h01);

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0;
      o_awready <= 1'b0;
      o_wready <= 1'b0;
      o_bvalid <= 1'b0;
      o_bresp <= 2'h0;
    end else begin
      o_awready <= !aw_have_q && !(i_awvalid && o_awready);
      o_wready <= !w_have_q && !(i_wvalid && o_wready);
      if (i_awvalid && o_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q <= i_awaddr;
      end
      if (i_wvalid && o_wready) begin
        w_have_q <= 1'b1;
        wdata_q <= i_wdata;
      end
      if (wr_go) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        o_bvalid <= 1'b1;
        o_bresp <= (awaddr_q > `TFG_REG_STATUS) ? 2'h2 : 2'h0;
      end else if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
      end
    end
  end

  // Register stores; partial strobes treated as full word writes
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      en_q <= 1'b0;
      lsb_q <= 1'b0;
      dir_q <= 1'b0;
      cmin_q <= 1'b0;
      bmode_q <= TFG_BLANK_OFF;
      wlen_q <= `TFG_RST_WLEN;
      wpf_q <= `TFG_RST_WPF;
      sync_q <= 32'h0;
      cmax_q <= `TFG_RST_CMAX;
      blen_q <= 16'h0;
      boff_q <= 16'h0;
      idx_q <= 6'h01;
    end else if (wr_go) begin
      case (awaddr_q)
        `TFG_REG_CTRL: begin
          en_q <= wdata_q[`TFG_CTRL_EN_BIT];
          lsb_q <= wdata_q[`TFG_CTRL_LSB_BIT];
          dir_q <= wdata_q[`TFG_CTRL_DIR_BIT];
          cmin_q <= wdata_q[`TFG_CTRL_CMIN_BIT];
          bmode_q <= tfg_blank_mode_t'(wdata_q[`TFG_CTRL_BMODE_LSB +: 2]);
        end
        `TFG_REG_FORMAT: begin
          wlen_q <= wdata_q[`TFG_FMT_WLEN_LSB +: 5];
          wpf_q <= wdata_q[`TFG_FMT_WPF_LSB +: 16];
        end
        `TFG_REG_SYNC: sync_q <= wdata_q;
        `TFG_REG_CNT_LIM: cmax_q <= wdata_q[15:0];
        `TFG_REG_BLANK: blen_q <= wdata_q[15:0];
        `TFG_REG_BLANK_RUN: boff_q <= wdata_q[15:0];
        `TFG_REG_ENTRY_IDX: begin
          // Out-of-range indices are ignored
          if (wdata_q[5:0] >= 6'h01 && wdata_q[5:0] <= 6'(DEPTH))
            idx_q <= wdata_q[5:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Program memory, one entry per generate slot
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_prog
      always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n)
          prog_q[g] <= 18'h0;
        else if (wr_go && awaddr_q == `TFG_REG_ENTRY_VAL && sel == IW'(g))
          prog_q[g] <= wdata_q[17:0];
      end
    end
  endgenerate

  // Error command: set wins over the consuming clear
  logic err_take;
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n)
      err_req_q <= 1'b0;
    else if (wr_go && awaddr_q == `TFG_REG_ERR_CMD && wdata_q[0])
      err_req_q <= 1'b1;
    else if (err_take)
      err_req_q <= 1'b0;
  end

  // AXI read path
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0;
      o_rresp <= 2'h0;
    end else begin
      o_arready <= !o_rvalid && !(i_arvalid && o_arready);
      if (i_arvalid && o_arready) begin
        o_rvalid <= 1'b1;
        o_rresp <= 2'h0;
        case (i_araddr)
          `TFG_REG_CTRL: o_rdata <= {26'h0, bmode_q, cmin_q, dir_q,
                                     lsb_q, en_q};
          `TFG_REG_FORMAT: o_rdata <= {wpf_q, 11'h0, wlen_q};
          `TFG_REG_SYNC: o_rdata <= sync_q;
          `TFG_REG_CNT_LIM: o_rdata <= {16'h0, cmax_q};
          `TFG_REG_BLANK: o_rdata <= {16'h0, blen_q};
          `TFG_REG_BLANK_RUN: o_rdata <= {16'h0, boff_q};
          `TFG_REG_ERR_CMD: o_rdata <= {31'h0, err_req_q};
          `TFG_REG_ENTRY_IDX: o_rdata <= {26'h0, idx_q};
          `TFG_REG_ENTRY_VAL: o_rdata <= {14'h0, prog_q[sel]};
          `TFG_REG_STATUS: o_rdata <= {o_blanking, 15'h0, fcnt_q};
          default: begin
            o_rdata <= 32'h0;
            o_rresp <= 2'h2;
          end
        endcase
      end else if (o_rvalid && i_rready) begin
        o_rvalid <= 1'b0;
      end
    end
  end

  // ****************
  // Frame sequencer
  // ****************
  logic [IW-1:0] pc_q;
  logic [15:0] rep_q, word_cnt_q, last_q;
  logic sync_half_q, in_rep_q;
  logic [15:0] shreg_q;
  logic [4:0] bit_q;
  logic [17:0] ent;
  tfg_op_t op;
  logic load_word, word_end, frame_end;
  logic [15:0] next_word, masked, coded;

  assign ent = prog_q[pc_q];
  assign op = tfg_op_t'(ent[`TFG_ENT_OP_LSB +: 2]);
  assign word_end = (bit_q == 5'h0);
  assign load_word = en_q && word_end;
  assign frame_end = (word_cnt_q + 16'h0001 >= wpf_q);

  always_comb begin
    next_word = last_q;
    if (in_rep_q)
      next_word = last_q;
    else case (op)
      TFG_OP_SYNC: next_word = sync_half_q ? sync_q[15:0]
                                           : sync_q[31:16];
      TFG_OP_IMM: next_word = ent[15:0];
      TFG_OP_REPEAT: next_word = last_q;
      TFG_OP_FCOUNT: next_word = fcnt_q;
      default: next_word = last_q;
    endcase
  end

  // Short words keep the low bits of the value
  always_comb begin
    masked = next_word & ((16'h0001 << wlen_q) - 16'h0001);
    if (wlen_q >= 5'(`TFG_SYNC_HALF_W))
      masked = next_word;
  end

  // Left-align so the shifter always emits from bit 15 down
  always_comb begin
    coded = masked << (5'(WMAX) - wlen_q);
    if (lsb_q)
      coded = {<<{masked}};
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pc_q <= '0;
      rep_q <= 16'h0;
      in_rep_q <= 1'b0;
      sync_half_q <= 1'b0;
      word_cnt_q <= 16'h0;
      last_q <= 16'h0;
      shreg_q <= 16'h0;
      bit_q <= 5'h0;
    end else if (!en_q) begin
      pc_q <= '0;
      word_cnt_q <= 16'h0;
      bit_q <= 5'h0;
      in_rep_q <= 1'b0;
      sync_half_q <= 1'b0;
    end else if (load_word) begin
      shreg_q <= coded;
      // Load cycle emits the first bit, so only wlen-1 shifts follow
      bit_q <= (wlen_q == 5'h0) ? 5'h0 : wlen_q - 5'h1;
      if (op != TFG_OP_REPEAT)
        last_q <= next_word;
      if (frame_end) begin
        pc_q <= '0;
        word_cnt_q <= 16'h0;
        in_rep_q <= 1'b0;
        sync_half_q <= 1'b0;
      end else begin
        word_cnt_q <= word_cnt_q + 16'h0001;
        if (op == TFG_OP_REPEAT && !in_rep_q && ent[15:0] > 16'h1) begin
          in_rep_q <= 1'b1;
          rep_q <= ent[15:0] - 16'h2;
        end else if (in_rep_q && rep_q != 16'h0) begin
          rep_q <= rep_q - 16'h1;
        end else if (op == TFG_OP_SYNC && !sync_half_q) begin
          sync_half_q <= 1'b1;
        end else begin
          in_rep_q <= 1'b0;
          sync_half_q <= 1'b0;
          pc_q <= (pc_q == IW'(DEPTH - 1)) ? '0 : pc_q + IW'(1);
        end
      end
    end else begin
      shreg_q <= {shreg_q[14:0], 1'b0};
      bit_q <= bit_q - 5'h1;
    end
  end

  // ****************
  // Frame counter
  // ****************
  logic [15:0] cmin;
  assign cmin = {15'h0, cmin_q};

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n)
      fcnt_q <= 16'h0;
    else if (!en_q)
      fcnt_q <= dir_q ? cmax_q : cmin;
    else if (load_word && frame_end) begin
      if (!dir_q)
        fcnt_q <= (fcnt_q >= cmax_q) ? cmin : fcnt_q + 16'h1;
      else
        fcnt_q <= (fcnt_q <= cmin) ? cmax_q : fcnt_q - 16'h1;
    end
  end

  // ****************
  // Error insert and output
  // ****************
  logic raw_bit, gen_valid, gen_start, err_bit;
  assign raw_bit = load_word ? coded[15] : shreg_q[14];
  assign gen_valid = en_q;
  assign gen_start = load_word && word_cnt_q == 16'h0;
  assign err_take = gen_valid && err_req_q;
  assign err_bit = raw_bit ^ err_take;

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_tx_bit_valid <= 1'b0;
      o_frame_start <= 1'b0;
    end else begin
      o_tx_bit_valid <= gen_valid;
      o_frame_start <= gen_start;
    end
  end

  tfg_blanker #(.CW(16)) u_blank (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_bit_valid(gen_valid),
    .i_bit(err_bit),
    .i_frame_start(gen_start),
    .i_mode(bmode_q),
    .i_blank_len(blen_q),
    .i_run_len(boff_q),
    .o_bit(o_tx_bit),
    .o_blanking(o_blanking)
  );

  property p_one_error;
    @(posedge i_clock) disable iff (!i_rst_n)
      err_take |=> !err_req_q || $past(wr_go);
  endproperty
  a_one_error: assert property (p_one_error)
    else $error("Error request not consumed after one bit");

  property p_restart;
    @(posedge i_clock) disable iff (!i_rst_n)
      (load_word && frame_end) |=> (pc_q == '0 && word_cnt_q == 16'h0);
  endproperty
  a_restart: assert property (p_restart)
    else $error("List did not restart at frame end");

  sequence s_word_load;
    load_word && wlen_q == 5'h10;
  endsequence

  sequence s_word_gap;
    !load_word [*8] ##1 !load_word [*7] ##1 load_word;
  endsequence

  property p_word_len;
    @(posedge i_clock) disable iff (!i_rst_n || !en_q)
      s_word_load |=> s_word_gap;
  endproperty
  a_word_len: assert property (p_word_len)
    else $error("Serialized word length wrong");

  property p_count_step;
    @(posedge i_clock) disable iff (!i_rst_n)
      (en_q && load_word && frame_end && !dir_q && fcnt_q < cmax_q)
        |=> fcnt_q == $past(fcnt_q) + 16'h1;
  endproperty
  a_count_step: assert property (p_count_step)
    else $error("Frame counter did not step by one");

  property p_wrap_up;
    @(posedge i_clock) disable iff (!i_rst_n)
      (en_q && load_word && frame_end && !dir_q && fcnt_q >= cmax_q)
        |=> fcnt_q == $past(cmin);
  endproperty
  a_wrap_up: assert property (p_wrap_up)
    else $error("Frame counter did not wrap to low limit");

  property p_idx_range;
    @(posedge i_clock) disable iff (!i_rst_n)
      idx_q >= 6'h01 && idx_q <= 6'(DEPTH);
  endproperty
  a_idx_range: assert property (p_idx_range)
    else $error("Entry index out of range");
endmodule

// ==== verif/tfg_link_rx.sv ====
`timescale 1ns/1ps
// ****************************************
// Far-side receiver model
// ****************************************
// Records three whole frames once armed. It only listens, so it drives
// nothing back towards the block.
module tfg_link_rx (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_bit,
  input wire logic i_bit_valid,
  input wire logic i_frame_start,
  input wire logic i_blanking,
  input wire logic i_arm,
  output logic [2:0] o_frames
);
  logic [2:0] frames_q;
  logic [8:0] idx_q;
  logic cap_bit_q [0:335];
  logic cap_blk_q [0:335];
  logic [2:0] cur;
  assign o_frames = frames_q;
  // Frame number that the bit at this edge belongs to
  assign cur = frames_q + {2'h0, i_frame_start};
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      frames_q <= 3'h0;
    end else if (!i_arm) begin
      frames_q <= 3'h0;
    end else if (i_frame_start && frames_q < 3'h4) begin
      frames_q <= frames_q + 3'h1;
    end
  end
  // The frame-start pulse stands with the first bit of its own frame
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      idx_q <= 9'h0;
    end else if (!i_arm) begin
      idx_q <= 9'h0;
    end else if (i_bit_valid && cur != 3'h0 && cur < 3'h4) begin
      cap_bit_q[idx_q] <= i_bit;
      cap_blk_q[idx_q] <= i_blanking;
      idx_q <= idx_q + 9'h1;
    end
  end
endmodule

// ==== verif/tb_tdm_frame_pattern_generator.sv ====
`timescale 1ns/1ps
`include "tfg_cfg.svh"
module tb_tdm_frame_pattern_generator;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic arm = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic tx_bit, tx_valid, fstart, blanking;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [2:0] frames;
  int n_mismatch = 0;
  int comparisons = 0;

  always #20 clock = ~clock;

  tfg_frame_gen tfg_frame_gen_i (.i_clock(clock), .i_rst_n(rst_n),
    .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
    .i_wdata(wdata), .i_wstrb(4'hf), .i_wvalid(wvalid), .o_wready(wready),
    .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
    .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
    .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
    .o_tx_bit(tx_bit), .o_tx_bit_valid(tx_valid), .o_frame_start(fstart),
    .o_blanking(blanking));

  tfg_link_rx tfg_link_rx_i (.i_clock(clock), .i_rst_n(rst_n),
    .i_bit(tx_bit), .i_bit_valid(tx_valid), .i_frame_start(fstart),
    .i_blanking(blanking), .i_arm(arm), .o_frames(frames));

  // ****************************************
  // Bus and check helpers
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge clock);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge clock);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic wait_frames(input logic [2:0] n);
    int k;
    k = 0;
    while (frames !== n && k < 2000) begin
      @(posedge clock);
      k++;
    end
    chk("frame wait", {29'h0, frames}, {29'h0, n});
  endtask

  function automatic logic [15:0] wexp(input int w, input logic [15:0] c);
    case (w)
      0: return 16'hfaf3;
      1: return 16'h3400;
      5: return c;
      6: return 16'h3c12;
      default: return 16'h00a5;
    endcase
  endfunction

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic regs();
    logic [31:0] d;
    logic [1:0] r;
    logic [17:0] prog [0:4];
    prog = '{18'h00000, 18'h100a5, 18'h20002, 18'h30000, 18'h13c12};
    rd(`TFG_REG_ENTRY_IDX, d, r);
    chk("index reset", d, 32'h1);
    rd(`TFG_REG_FORMAT, d, r);
    chk("format reset", d, 32'h00100010);
    rd(`TFG_REG_CNT_LIM, d, r);
    chk("limit reset", d, 32'h0000ffff);
    rd(8'h28, d, r);
    chk("unmapped read", {d[29:0], r}, 32'h2);
    wr(8'h28, 32'h1, r);
    chk("unmapped write", {30'h0, r}, 32'h2);
    wr(`TFG_REG_FORMAT, 32'h00070010, r);
    wr(`TFG_REG_SYNC, 32'hfaf33400, r);
    for (int k = 0; k < 5; k++) begin
      wr(`TFG_REG_ENTRY_IDX, 32'(k + 1), r);
      wr(`TFG_REG_ENTRY_VAL, {14'h0, prog[k]}, r);
    end
    wr(`TFG_REG_ENTRY_IDX, 32'h4, r);
    rd(`TFG_REG_ENTRY_VAL, d, r);
    chk("entry readback", d, 32'h00030000);
    wr(`TFG_REG_ENTRY_IDX, 32'h21, r);
    rd(`TFG_REG_ENTRY_IDX, d, r);
    chk("index range", d, 32'h4);
    wr(`TFG_REG_ENTRY_IDX, 32'h20, r);
    wr(`TFG_REG_ENTRY_VAL, 32'h00015a5a, r);
    rd(`TFG_REG_ENTRY_VAL, d, r);
    chk("last entry", d, 32'h00015a5a);
  endtask

  // Frame is 7 words of 16 bits: sync pair, three copies, counter, value
  task automatic check_run(input bit lsb, dn, err, input logic [15:0] lo,
                           hi, input logic [1:0] mode);
    logic [15:0] cnt [0:2];
    logic [15:0] w;
    logic [15:0] nx;
    int p, diffs, ones, nblk, first, viol, per;
    diffs = 0;
    ones = 0;
    nblk = 0;
    first = -1;
    viol = 0;
    per = (mode == 2'h2) ? 112 : 8;
    for (int f = 0; f < 3; f++) begin
      for (int b = 0; b < 16; b++) begin
        cnt[f][lsb ? b : 15 - b] = tfg_link_rx_i.cap_bit_q[f * 112 + 80 + b];
      end
    end
    if (mode == 2'h0) begin
      chk("count range", 32'(cnt[0] >= lo && cnt[0] <= hi), 32'h1);
      for (int f = 0; f < 2; f++) begin
        nx = dn ? (cnt[f] == lo ? hi : cnt[f] - 16'h1)
                : (cnt[f] == hi ? lo : cnt[f] + 16'h1);
        chk("count step", {16'h0, cnt[f + 1]}, {16'h0, nx});
      end
    end
    for (int i = 0; i < 336; i++) begin
      p = i % 112;
      w = wexp(p / 16, cnt[i / 112]);
      if (i >= per && tfg_link_rx_i.cap_blk_q[i] !==
          tfg_link_rx_i.cap_blk_q[i - per]) viol++;
      if (tfg_link_rx_i.cap_blk_q[i] === 1'b1) begin
        nblk++;
        if (tfg_link_rx_i.cap_bit_q[i] !== 1'b0) ones++;
        if (first < 0) first = p;
      end else if (tfg_link_rx_i.cap_bit_q[i] !==
                   w[lsb ? p % 16 : 15 - p % 16]) begin
        diffs++;
      end
    end
    chk("bit errors", 32'(diffs), 32'(err));
    chk("blank ones", 32'(ones), 32'h0);
    chk("blank period", 32'(viol), 32'h0);
    case (mode)
      2'h1: chk("blank free", 32'(nblk), 32'd126);
      2'h2: chk("blank frame", 32'(nblk), 32'd12);
      default: chk("blank off", 32'(nblk), 32'h0);
    endcase
    if (mode == 2'h2) chk("blank start", 32'(first), 32'd10);
  endtask

  task automatic run(input bit lsb, dn, err, input logic [15:0] lo, hi,
                     input logic [1:0] mode, input logic [15:0] blen, rlen);
    logic [31:0] ctl;
    logic [31:0] d;
    logic [1:0] r;
    ctl = {26'h0, mode, lo[0], dn, lsb, 1'b0};
    wr(`TFG_REG_CNT_LIM, {16'h0, hi}, r);
    wr(`TFG_REG_BLANK, {16'h0, blen}, r);
    wr(`TFG_REG_BLANK_RUN, {16'h0, rlen}, r);
    wr(`TFG_REG_CTRL, ctl, r);
    wr(`TFG_REG_CTRL, ctl | 32'h1, r);
    @(posedge clock);
    arm <= 1'b1;
    wait_frames(3'h1);
    if (err) wr(`TFG_REG_ERR_CMD, 32'h1, r);
    wait_frames(3'h4);
    if (err) begin
      rd(`TFG_REG_ERR_CMD, d, r);
      chk("error pending", {31'h0, d[0]}, 32'h0);
    end
    wr(`TFG_REG_CTRL, ctl, r);
    @(posedge clock);
    arm <= 1'b0;
    check_run(lsb, dn, err, lo, hi, mode);
  endtask

  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial begin
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    regs();
    run(1'b0, 1'b0, 1'b0, 16'h1, 16'h2, 2'h0, 16'h0, 16'h0);
    run(1'b1, 1'b1, 1'b1, 16'h0, 16'h2, 2'h0, 16'h0, 16'h0);
    run(1'b0, 1'b0, 1'b0, 16'h1, 16'h2, 2'h1, 16'h3, 16'h5);
    run(1'b0, 1'b0, 1'b0, 16'h1, 16'h2, 2'h2, 16'h4, 16'ha);
    report_and_stop();
  end

  // Whole run needs about two thousand cycles; this bound only cuts a hang
  initial begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    report_and_stop();
  end
endmodule
